// File: src/lpmc_defines.svh
// Constants for the low-power mode controller: APB offsets, fields, reset values.
// Assumes a 32-bit APB master and a 50 MHz bus clock.
`ifndef LPMC_DEFINES_SVH
`define LPMC_DEFINES_SVH
`define LPMC_OFS_CTRL 12'h000
`define LPMC_OFS_STATUS 12'h004
`define LPMC_OFS_CLKCFG 12'h008
`define LPMC_OFS_VECTOR 12'h00C
`define LPMC_BIT_STOP_MODE_ENABLE 0
`define LPMC_BIT_DBGEN 1
`define LPMC_BIT_VOLTAGE_DETECT_ENABLE 2
`define LPMC_BIT_VOLTAGE_DETECT_IN_STOP 3
`define LPMC_BIT_OSCSTOP 0
`define LPMC_BIT_IREFSTOP 1
`define LPMC_REALTIME_PRESCALE_SELECT_LSB 4
`define LPMC_REALTIME_PRESCALE_SELECT_W 4
`define LPMC_CTRL_RST 4'h4
`define LPMC_CLK_RST 8'h00
`define LPMC_RESET_VEC 16'hFFFE
`define LPMC_WAKE_SRCS 7
`endif

// File: src/lpmc_pkg.sv
// Types of the low-power mode controller.
// Assumes lpmc_defines.svh is included by users of the offsets.
package lpmc_pkg;
   typedef enum logic [3:0] {
      LPMC_RUN = 4'h1,
      LPMC_WAIT = 4'h2,
      LPMC_STOP = 4'h4,
      LPMC_BDM = 4'h8
   } lpmc_mode_t;
endpackage : lpmc_pkg

// File: src/lpmc_ctrl.sv
// Low-power mode controller: run, wait, stop3 and active background sequencing.
// Assumes CPU events are one-cycle pulses on mclk_in; wake sources are async pins.
`timescale 1ns/1ps
`include "lpmc_defines.svh"
module lpmc_ctrl
   import lpmc_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic wait_exec_in,
   input wire logic stop_exec_in,
   input wire logic [`LPMC_WAKE_SRCS-1:0] wake_irq_in,
   input wire logic bdm_bgnd_cmd_in,
   input wire logic bdm_mem_cmd_in,
   input wire logic bdm_other_cmd_in,
   input wire logic rti_tick_in,
   output logic cpu_clk_en_out,
   output logic bus_clk_en_out,
   output logic dbg_clk_en_out,
   output logic osc_clk_en_out,
   output logic iref_clk_en_out,
   output logic rtc_clk_en_out,
   output logic lpo_en_out,
   output logic reg_full_out,
   output logic lvd_en_out,
   output logic clkgen_stby_out,
   output logic adc_stby_out,
   output logic cpu_stby_out,
   output logic flash_stby_out,
   output logic ram_stby_out,
   output logic clear_imask_out,
   output logic irq_resume_out,
   output logic [15:0] fetch_vec_out,
   output logic bdm_accept_out,
   output logic bdm_err_out,
   output logic illegal_stop_out
);
   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef struct packed {
      lpmc_mode_t mode;
      logic [3:0] ctrl;
      logic [7:0] clkcfg;
      logic [2:0][`LPMC_WAKE_SRCS-1:0] sync;
      logic [2:0] bg_sync;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic cpu_clk;
      logic bus_clk;
      logic dbg_clk;
      logic osc_clk;
      logic iref_clk;
      logic rtc_clk;
      logic reg_full;
      logic lvd_en;
      logic clkgen_stby;
      logic adc_stby;
      logic cpu_stby;
      logic flash_stby;
      logic ram_stby;
      logic clr_imask;
      logic irq_resume;
      logic [15:0] vec;
      logic bdm_accept;
      logic bdm_err;
      logic illegal;
      logic stop_dbg;
      logic stop_lvd;
   } lpmc_state_t;

   lpmc_state_t st;
   lpmc_state_t next_st;

   logic [`LPMC_WAKE_SRCS-1:0] wake_stable;
   logic bg_stable;
   logic low_power;
   logic realtime_prescale_select_on;

   // Second and third stages agree before a wake counts
   assign wake_stable = st.sync[1] & st.sync[2];
   assign bg_stable = st.bg_sync[1] & st.bg_sync[2];
   assign low_power = (st.mode == LPMC_WAIT) || (st.mode == LPMC_STOP);
   assign realtime_prescale_select_on = |st.clkcfg[`LPMC_REALTIME_PRESCALE_SELECT_LSB +: `LPMC_REALTIME_PRESCALE_SELECT_W];

   always_comb begin
      next_st = st;
      next_st.sync[0] = wake_irq_in;
      next_st.sync[1] = st.sync[0];
      next_st.sync[2] = st.sync[1];
      next_st.bg_sync[0] = bdm_bgnd_cmd_in;
      next_st.bg_sync[1] = st.bg_sync[0];
      next_st.bg_sync[2] = st.bg_sync[1];
      next_st.clr_imask = 1'b0;
      next_st.irq_resume = 1'b0;
      next_st.bdm_accept = 1'b0;
      next_st.bdm_err = 1'b0;
      next_st.illegal = 1'b0;
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      // -------------------------------------------------------------
      // APB slave, one wait state
      // -------------------------------------------------------------
      if (psel_in && penable_in && !st.pready) begin
         next_st.pready = 1'b1;
         next_st.prdata = 32'h0000_0000;
         unique case (paddr_in)
            `LPMC_OFS_CTRL: begin
               next_st.prdata = {28'h0000000, st.ctrl};
            end
            `LPMC_OFS_STATUS: begin
               next_st.prdata = {28'h0000000, st.mode};
            end
            `LPMC_OFS_CLKCFG: begin
               next_st.prdata = {24'h000000, st.clkcfg};
            end
            `LPMC_OFS_VECTOR: begin
               next_st.prdata = {16'h0000, st.vec};
            end
            default: begin
               next_st.pslverr = 1'b1;
            end
         endcase
      end
      // Write lands only on the completing edge, pready high
      if (psel_in && penable_in && pwrite_in && st.pready) begin
         if (paddr_in == `LPMC_OFS_CTRL) next_st.ctrl = pwdata_in[3:0];
         if (paddr_in == `LPMC_OFS_CLKCFG) next_st.clkcfg = pwdata_in[7:0];
      end
      // -------------------------------------------------------------
      // Mode sequencing
      // -------------------------------------------------------------
      unique case (st.mode)
         LPMC_RUN: begin
            if (wait_exec_in) begin
               next_st.mode = LPMC_WAIT;
               next_st.clr_imask = 1'b1;
            end else if (stop_exec_in) begin
               next_st.clr_imask = 1'b1;
               if (st.ctrl[`LPMC_BIT_STOP_MODE_ENABLE]) begin
                  next_st.mode = LPMC_STOP;
                  next_st.stop_dbg = st.ctrl[`LPMC_BIT_DBGEN];
                  next_st.stop_lvd = st.ctrl[`LPMC_BIT_VOLTAGE_DETECT_ENABLE] & st.ctrl[`LPMC_BIT_VOLTAGE_DETECT_IN_STOP];
               end else begin
                  next_st.illegal = 1'b1;
               end
            end else if (bg_stable && st.ctrl[`LPMC_BIT_DBGEN]) begin
               next_st.mode = LPMC_BDM;
            end
         end
         LPMC_WAIT: begin
            if (bg_stable) begin
               next_st.mode = LPMC_BDM;
            end else if (|wake_stable) begin
               next_st.mode = LPMC_RUN;
               next_st.irq_resume = 1'b1;
            end
         end
         LPMC_STOP: begin
            if (bg_stable && st.ctrl[`LPMC_BIT_DBGEN]) begin
               next_st.mode = LPMC_BDM;
            end else if (|wake_stable || (rti_tick_in && realtime_prescale_select_on)) begin
               next_st.mode = LPMC_RUN;
               next_st.irq_resume = 1'b1;
            end
         end
         LPMC_BDM: begin
            if (!st.ctrl[`LPMC_BIT_DBGEN]) next_st.mode = LPMC_RUN;
         end
      endcase
      if (low_power) begin
         next_st.bdm_accept = bg_stable | bdm_mem_cmd_in;
         next_st.bdm_err = bdm_mem_cmd_in;
      end else begin
         next_st.bdm_accept = bg_stable | bdm_mem_cmd_in | bdm_other_cmd_in;
      end
      // -------------------------------------------------------------
      // Clock, regulator and standby outputs from next mode; rtc clock from clkcfg in every mode
      // -------------------------------------------------------------
      // bus clocks, full regulation
      next_st.cpu_clk = (next_st.mode == LPMC_RUN) || (next_st.mode == LPMC_BDM);
      next_st.bus_clk = (next_st.mode != LPMC_STOP);
      next_st.cpu_stby = (next_st.mode == LPMC_WAIT) || (next_st.mode == LPMC_STOP);
      next_st.ram_stby = next_st.cpu_stby;
      next_st.flash_stby = (next_st.mode == LPMC_STOP);
      if (next_st.mode == LPMC_STOP) begin
         next_st.osc_clk = ~st.clkcfg[`LPMC_BIT_OSCSTOP] ? 1'b0 : 1'b1;
         next_st.iref_clk = st.clkcfg[`LPMC_BIT_IREFSTOP];
         next_st.dbg_clk = next_st.stop_dbg;
         next_st.clkgen_stby = 1'b1;
         next_st.adc_stby = 1'b1;
         next_st.reg_full = next_st.stop_dbg | next_st.stop_lvd;
         next_st.lvd_en = st.ctrl[`LPMC_BIT_VOLTAGE_DETECT_ENABLE] &
            (st.ctrl[`LPMC_BIT_VOLTAGE_DETECT_IN_STOP] | next_st.stop_dbg);
      end else begin
         next_st.osc_clk = 1'b1;
         next_st.iref_clk = 1'b1;
         next_st.dbg_clk = 1'b1;
         next_st.clkgen_stby = 1'b0;
         next_st.adc_stby = 1'b0;
         next_st.reg_full = 1'b1;
         next_st.lvd_en = st.ctrl[`LPMC_BIT_VOLTAGE_DETECT_ENABLE];
      end
      next_st.rtc_clk = realtime_prescale_select_on;
   end

   // pins held by retained state, no latch
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st <= '0;
         st.mode <= LPMC_RUN;
         st.ctrl <= `LPMC_CTRL_RST;
         st.clkcfg <= `LPMC_CLK_RST;
         st.cpu_clk <= 1'b1;
         st.bus_clk <= 1'b1;
         st.dbg_clk <= 1'b1;
         st.osc_clk <= 1'b1;
         st.iref_clk <= 1'b1;
         st.reg_full <= 1'b1;
         st.lvd_en <= 1'b1;
         st.vec <= `LPMC_RESET_VEC;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_out = st.prdata;
   assign pready_out = st.pready;
   assign pslverr_out = st.pslverr;
   assign cpu_clk_en_out = st.cpu_clk;
   assign bus_clk_en_out = st.bus_clk;
   assign dbg_clk_en_out = st.dbg_clk;
   assign osc_clk_en_out = st.osc_clk;
   assign iref_clk_en_out = st.iref_clk;
   assign rtc_clk_en_out = st.rtc_clk;
   // Oscillator never stops; it carries the stop3 wake timer
   assign lpo_en_out = 1'b1;
   assign reg_full_out = st.reg_full;
   assign lvd_en_out = st.lvd_en;
   assign clkgen_stby_out = st.clkgen_stby;
   assign adc_stby_out = st.adc_stby;
   assign cpu_stby_out = st.cpu_stby;
   assign flash_stby_out = st.flash_stby;
   assign ram_stby_out = st.ram_stby;
   assign clear_imask_out = st.clr_imask;
   assign irq_resume_out = st.irq_resume;
   assign fetch_vec_out = st.vec;
   assign bdm_accept_out = st.bdm_accept;
   assign bdm_err_out = st.bdm_err;
   assign illegal_stop_out = st.illegal;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   property p_wait_gate;
      @(posedge mclk_in) disable iff (!resetn_in)
      (st.mode == LPMC_RUN && wait_exec_in) |=> (!cpu_clk_en_out && bus_clk_en_out);
   endproperty
   a_wait_gate: assert property (p_wait_gate) else $error("wait did not gate cpu");

   property p_wait_full;
      @(posedge mclk_in) disable iff (!resetn_in)
      (st.mode == LPMC_WAIT) |-> (reg_full_out && bus_clk_en_out);
   endproperty
   a_wait_full: assert property (p_wait_full) else $error("wait lost regulation");

   property p_imask;
      @(posedge mclk_in) disable iff (!resetn_in)
      (st.mode == LPMC_RUN && (wait_exec_in || stop_exec_in)) |=> clear_imask_out;
   endproperty
   a_imask: assert property (p_imask) else $error("mask not cleared");

   property p_stop_en;
      @(posedge mclk_in) disable iff (!resetn_in)
      (st.mode == LPMC_RUN && !wait_exec_in && stop_exec_in && !st.ctrl[`LPMC_BIT_STOP_MODE_ENABLE])
         |=> (st.mode != LPMC_STOP && illegal_stop_out);
   endproperty
   a_stop_en: assert property (p_stop_en) else $error("stop entered while disabled");

   property p_lp_err;
      @(posedge mclk_in) disable iff (!resetn_in)
      (low_power && bdm_mem_cmd_in) |=> bdm_err_out;
   endproperty
   a_lp_err: assert property (p_lp_err) else $error("status error missing");

   property p_stop_reg;
      @(posedge mclk_in) disable iff (!resetn_in)
      (st.mode == LPMC_STOP && !st.stop_dbg && !st.stop_lvd) |-> !reg_full_out;
   endproperty
   a_stop_reg: assert property (p_stop_reg) else $error("stop3 not loose");

   property p_stop_dbg;
      @(posedge mclk_in) disable iff (!resetn_in)
      (st.mode == LPMC_STOP && st.stop_dbg) |-> (dbg_clk_en_out && reg_full_out);
   endproperty
   a_stop_dbg: assert property (p_stop_dbg) else $error("debug clocks lost");

   property p_wake_wait;
      @(posedge mclk_in) disable iff (!resetn_in)
      (st.mode == LPMC_WAIT && |wake_irq_in && !bdm_bgnd_cmd_in) [*3]
         |-> ##[1:2] (st.mode != LPMC_WAIT);
   endproperty
   a_wake_wait: assert property (p_wake_wait) else $error("wait wake missed");

   property p_stop_lvd;
      @(posedge mclk_in) disable iff (!resetn_in)
      (st.mode == LPMC_STOP && st.stop_lvd) |-> reg_full_out;
   endproperty
   a_stop_lvd: assert property (p_stop_lvd) else $error("detect in stop lost regulator");

   property p_wait_stby;
      @(posedge mclk_in) disable iff (!resetn_in)
      (st.mode == LPMC_WAIT) |-> (cpu_stby_out && ram_stby_out && !flash_stby_out);
   endproperty
   a_wait_stby: assert property (p_wait_stby) else $error("wait standby wrong");

   property p_bg_wake;
      @(posedge mclk_in) disable iff (!resetn_in)
      (st.mode == LPMC_WAIT && bg_stable) |=> (st.mode == LPMC_BDM);
   endproperty
   a_bg_wake: assert property (p_bg_wake) else $error("background did not wake wait");
endmodule : lpmc_ctrl

// File: verif/lpmc_core_model.sv
// CPU core and debug port stand-in: instruction events and debug commands.
// Assumes the controller samples these on rising edges of mclk_in.
`timescale 1ns/1ps
module lpmc_core_model (
   input wire logic mclk_in,
   output logic wait_exec_out,
   output logic stop_exec_out,
   output logic bgnd_cmd_out,
   output logic mem_cmd_out,
   output logic other_cmd_out
);
   initial begin
      {wait_exec_out, stop_exec_out, mem_cmd_out, other_cmd_out, bgnd_cmd_out} = 5'h00;
   end
   // one event per pulse
   // Sel is {wait, stop, memory command, other command}; one cycle wide
   task automatic pulse(input logic [3:0] sel);
      @(posedge mclk_in);
      {wait_exec_out, stop_exec_out, mem_cmd_out, other_cmd_out} <= sel;
      @(posedge mclk_in);
      {wait_exec_out, stop_exec_out, mem_cmd_out, other_cmd_out} <= 4'h0;
   endtask : pulse
   // Background command is a level until the controller reacts
   task automatic set_bgnd(input logic v);
      @(posedge mclk_in);
      bgnd_cmd_out <= v;
   endtask : set_bgnd
endmodule : lpmc_core_model

// File: verif/low_power_mode_controller_tb.sv
// Self-checking bench for the low-power mode controller.
// Assumes lpmc_ctrl with one wait state on APB and the core model beside it.
`timescale 1ns/1ps
`include "lpmc_defines.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fail_count++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module low_power_mode_controller_tb;
   import lpmc_pkg::*;
   logic mclk_in = 1'b0;
   logic resetn_in, psel_in, penable_in, pwrite_in;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out;
   logic [6:0] wake_irq_in;
   logic rti_tick_in, pready_out, pslverr_out, wait_exec_in, stop_exec_in;
   logic bdm_bgnd_cmd_in, bdm_mem_cmd_in, bdm_other_cmd_in, cpu_clk_en_out, bus_clk_en_out;
   logic dbg_clk_en_out, osc_clk_en_out, iref_clk_en_out, rtc_clk_en_out, lpo_en_out;
   logic reg_full_out, lvd_en_out, clkgen_stby_out, adc_stby_out, cpu_stby_out;
   logic flash_stby_out, ram_stby_out, clear_imask_out, irq_resume_out, bdm_accept_out;
   logic bdm_err_out, illegal_stop_out;
   logic [15:0] fetch_vec_out;
   int fail_count = 0, num_checks = 0;
   always #10 mclk_in = ~mclk_in;
   lpmc_core_model core (.mclk_in, .wait_exec_out(wait_exec_in), .stop_exec_out(stop_exec_in),
      .bgnd_cmd_out(bdm_bgnd_cmd_in), .mem_cmd_out(bdm_mem_cmd_in),
      .other_cmd_out(bdm_other_cmd_in));
   lpmc_ctrl dut (.mclk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .wait_exec_in, .stop_exec_in,
      .wake_irq_in, .bdm_bgnd_cmd_in, .bdm_mem_cmd_in, .bdm_other_cmd_in, .rti_tick_in,
      .cpu_clk_en_out, .bus_clk_en_out, .dbg_clk_en_out, .osc_clk_en_out, .iref_clk_en_out,
      .rtc_clk_en_out, .lpo_en_out, .reg_full_out, .lvd_en_out, .clkgen_stby_out,
      .adc_stby_out, .cpu_stby_out, .flash_stby_out, .ram_stby_out, .clear_imask_out,
      .irq_resume_out, .fetch_vec_out, .bdm_accept_out, .bdm_err_out, .illegal_stop_out);
   // ----------------------------------------
   // Bus and helper tasks
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
      int n;
      @(posedge mclk_in);
      psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= wr; paddr_in <= a; pwdata_in <= d;
      @(posedge mclk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin @(posedge mclk_in); n++; end while (pready_out !== 1'b1 && n < 20);
      q = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0; penable_in <= 1'b0;
      if (n >= 20) `CHK("pready", 1'b1, 1'b0)
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q; logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] ex);
      logic [31:0] q; logic e;
      apb(1'b0, a, 32'h0, q, e);
      `CHK(nm, ex, q)
   endtask : rd
   // Sources 0..6 are wake pins, 7 is the real-time tick
   task automatic wake(input int src);
      int n;
      @(posedge mclk_in);
      if (src < 7) wake_irq_in[src] <= 1'b1; else rti_tick_in <= 1'b1;
      n = 0;
      do begin @(posedge mclk_in); rti_tick_in <= 1'b0; n++; end
      while (irq_resume_out !== 1'b1 && n < 12);
      `CHK("irq_resume", 1'b1, irq_resume_out)
      `CHK("cpu_clk_back", 1'b1, cpu_clk_en_out)
      wake_irq_in <= 7'h00;
      repeat (5) @(posedge mclk_in);
   endtask : wake
   task automatic to_bdm();
      int n; logic [31:0] q; logic e;
      core.set_bgnd(1'b1);
      n = 0;
      do begin apb(1'b0, `LPMC_OFS_STATUS, 32'h0, q, e); n++; end while (q !== 32'h8 && n < 10);
      core.set_bgnd(1'b0);
      `CHK("bdm_mode", 32'h8, q)
      core.pulse(4'h1);
      #1 `CHK("bdm_all_cmds", 1'b1, bdm_accept_out)
   endtask : to_bdm
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [31:0] q; logic e;
      `CHK("fetch_vec", 16'hFFFE, fetch_vec_out)
      `CHK("reg_full", 1'b1, reg_full_out)
      `CHK("cpu_clk", 1'b1, cpu_clk_en_out)
      `CHK("lpo", 1'b1, lpo_en_out)
      rd("status", `LPMC_OFS_STATUS, 32'h1);
      rd("ctrl", `LPMC_OFS_CTRL, 32'h4);
      rd("clkcfg", `LPMC_OFS_CLKCFG, 32'h0);
      rd("vector", `LPMC_OFS_VECTOR, 32'hFFFE);
      apb(1'b0, 12'h010, 32'h0, q, e);
      `CHK("unmapped_err", 1'b1, e)
      wr(`LPMC_OFS_STATUS, 32'h2);
      rd("status_ro", `LPMC_OFS_STATUS, 32'h1);
      $display("test reset done");
   endtask : t_reset
   task automatic t_wait();
      wr(`LPMC_OFS_CTRL, 32'h6);
      core.pulse(4'h8);
      #1 `CHK("imask_clr", 1'b1, clear_imask_out);
      `CHK("cpu_clk", 1'b0, cpu_clk_en_out)
      `CHK("bus_clk", 1'b1, bus_clk_en_out)
      `CHK("reg_full", 1'b1, reg_full_out)
      `CHK("stby", 3'b101, {cpu_stby_out, flash_stby_out, ram_stby_out})
      core.pulse(4'h2);
      #1 `CHK("mem_cmd", 2'b11, {bdm_accept_out, bdm_err_out});
      core.pulse(4'h1);
      #1 `CHK("other_cmd", 1'b0, bdm_accept_out);
      wake(3);
      core.pulse(4'h8);
      to_bdm();
      wr(`LPMC_OFS_CTRL, 32'h4);
      rd("run_again", `LPMC_OFS_STATUS, 32'h1);
      $display("test wait done");
   endtask : t_wait
   task automatic t_stop();
      wr(`LPMC_OFS_CTRL, 32'h4);
      core.pulse(4'h4);
      #1 `CHK("illegal_stop", 1'b1, illegal_stop_out);
      rd("no_stop", `LPMC_OFS_STATUS, 32'h1);
      wr(`LPMC_OFS_CTRL, 32'h5);
      for (int i = 0; i < 7; i++) begin
         core.pulse(4'h4);
         #1 `CHK("imask_clr", 1'b1, clear_imask_out);
         `CHK("clocks", 6'h00, {cpu_clk_en_out, bus_clk_en_out, dbg_clk_en_out,
            osc_clk_en_out, iref_clk_en_out, rtc_clk_en_out})
         `CHK("reg_full", 1'b0, reg_full_out)
         `CHK("lvd_en", 1'b0, lvd_en_out)
         `CHK("stby", 5'h1F, {clkgen_stby_out, adc_stby_out, cpu_stby_out,
            flash_stby_out, ram_stby_out})
         `CHK("lpo", 1'b1, lpo_en_out)
         wake(i);
      end
      $display("test stop done");
   endtask : t_stop
   task automatic t_keep();
      wr(`LPMC_OFS_CLKCFG, 32'h13);
      core.pulse(4'h4);
      #1 `CHK("osc_iref_rtc", 3'b111, {osc_clk_en_out, iref_clk_en_out, rtc_clk_en_out});
      core.set_bgnd(1'b1);
      repeat (8) @(posedge mclk_in);
      #1 `CHK("bgnd_no_wake", 1'b0, cpu_clk_en_out);
      core.set_bgnd(1'b0);
      wake(7);
      wr(`LPMC_OFS_CTRL, 32'hD);
      core.pulse(4'h4);
      #1 `CHK("lvd_keep", 2'b11, {reg_full_out, lvd_en_out});
      core.pulse(4'h2);
      #1 `CHK("mem_cmd", 2'b11, {bdm_accept_out, bdm_err_out});
      wake(6);
      wr(`LPMC_OFS_CTRL, 32'h3);
      core.pulse(4'h4);
      #1 `CHK("dbg_keep", 2'b11, {dbg_clk_en_out, reg_full_out});
      to_bdm();
      wr(`LPMC_OFS_CTRL, 32'h1);
      rd("run_again", `LPMC_OFS_STATUS, 32'h1);
      $display("test keep done");
   endtask : t_keep
   task automatic t_reset_exit();
      core.pulse(4'h4);
      @(posedge mclk_in);
      `CHK("stop_entered", 1'b0, bus_clk_en_out)
      resetn_in <= 1'b0;
      @(posedge mclk_in);
      `CHK("rst_vec", 16'hFFFE, fetch_vec_out)
      `CHK("rst_run", 3'b111, {cpu_clk_en_out, bus_clk_en_out, reg_full_out})
      resetn_in <= 1'b1;
      @(posedge mclk_in);
      rd("rst_status", `LPMC_OFS_STATUS, 32'h1);
      rd("rst_ctrl", `LPMC_OFS_CTRL, 32'h4);
      $display("test reset exit done");
   endtask : t_reset_exit
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   initial begin
      resetn_in <= 1'b0;
      {psel_in, penable_in, pwrite_in, rti_tick_in} <= 4'h0;
      paddr_in <= 12'h000;
      pwdata_in <= 32'h0000_0000;
      wake_irq_in <= 7'h00;
      repeat (5) @(posedge mclk_in);
      resetn_in <= 1'b1;
      @(posedge mclk_in);
      t_reset();
      t_wait();
      t_stop();
      t_keep();
      t_reset_exit();
      summarize();
   end
   // Run needs well under 2000 cycles
   initial begin
      #200000;
      fail_count++;
      summarize();
   end
endmodule : low_power_mode_controller_tb
